//--- logic/incl_cfg.svh
// Overview of operation
// - 16-bit registers, each byte own 6-bit address
// - only complete 16-clock frames set next response
// - full duplex: response out, command in together
// - upper byte at lower byte address plus one
// - bit15 new data, bit14 error, 14 data
// - 12-bit outputs leave top two bits zero
// - new data clears on read, sets on sample
// - error flag mirrors any diagnostic flag set
// - even addresses 0x00-0x3e, access per register
// - flash mirror updated only by trigger bit
// - read-only flash write counter at 0x00
// - supply reading 14-bit unsigned, 0.30518 mV/LSB
// - accel, tilt, angle 14-bit two's complement
// - auxiliary converter 12-bit unsigned, 0.6105 mV/LSB
// - temperature 12-bit unsigned, -0.47 C/LSB
// - angle wraps: +180 one LSB from -179.975
// - five flash-backed offsets at 0x12 to 0x1a
// - flash-backed alarm settings at 0x20 to 0x28
// - sleep 0x3a write-only flashed; trigger 0x3e write-only
// - link clock idles high, mode 1/1
`ifndef INCL_CFG_SVH
`define INCL_CFG_SVH
`define INCL_OFS_ENDUR     6'h00
`define INCL_OFS_SUPPLY    6'h02
`define INCL_OFS_XACC      6'h04
`define INCL_OFS_YACC      6'h06
`define INCL_OFS_AUX       6'h08
`define INCL_OFS_TEMP      6'h0a
`define INCL_OFS_XTILT     6'h0c
`define INCL_OFS_YTILT     6'h0e
`define INCL_OFS_ANGLE     6'h10
`define INCL_OFS_XACC_OFF  6'h12
`define INCL_OFS_YACC_OFF  6'h14
`define INCL_OFS_XTILT_OFF 6'h16
`define INCL_OFS_YTILT_OFF 6'h18
`define INCL_OFS_ANGLE_OFF 6'h1a
`define INCL_OFS_ALM1_THR  6'h20
`define INCL_OFS_ALM2_THR  6'h22
`define INCL_OFS_ALM1_PER  6'h24
`define INCL_OFS_ALM2_PER  6'h26
`define INCL_OFS_ALARM_SOURCE_CONTROL  6'h28
`define INCL_OFS_DAC       6'h30
`define INCL_OFS_GPIO      6'h32
`define INCL_OFS_MISC      6'h34
`define INCL_OFS_SMPL      6'h36
`define INCL_OFS_AVG       6'h38
`define INCL_OFS_SLP       6'h3a
`define INCL_OFS_DIAG      6'h3c
`define INCL_OFS_TRIG      6'h3e
`define INCL_RST_SMPL      16'h0014
`define INCL_RST_AVG       16'h0008
`define INCL_RST_ZERO      16'h0000
`define INCL_TRIG_FLASH    3
`define INCL_GPIO_DIR_LSB  0
`define INCL_GPIO_DAT_LSB  8
`endif

//--- logic/incl_pkg.sv
package incl_pkg;
    typedef logic [15:0] incl_word_t;

    // one link frame, first bit shifted in is wr
    typedef struct packed {
        logic       wr;
        logic       spare;
        logic [5:0] addr;
        logic [7:0] data;
    } incl_cmd_s;

    // one converted sample set from the sensing path
    typedef struct packed {
        logic [13:0] supply;
        logic [13:0] x_accel;
        logic [13:0] y_accel;
        logic [11:0] aux;
        logic [11:0] temp;
        logic [13:0] x_tilt;
        logic [13:0] y_tilt;
        logic [13:0] angle;
    } incl_sample_s;

    typedef struct packed {
        incl_word_t x_accel_offset;
        incl_word_t y_accel_offset;
        incl_word_t x_tilt_offset;
        incl_word_t y_tilt_offset;
        incl_word_t vertical_angle_offset;
        incl_word_t alarm1_threshold;
        incl_word_t alarm2_threshold;
        incl_word_t alarm1_period;
        incl_word_t alarm2_period;
        incl_word_t alarm_source_control;
        incl_word_t analog_output_code;
        incl_word_t dataready_selftest_control;
        incl_word_t sample_period_config;
        incl_word_t filter_length_config;
        incl_word_t sleep_duration;
    } incl_cfg_s;
endpackage : incl_pkg

//--- logic/incl_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "incl_cfg.svh"
module incl_regs (
    input  wire logic                   clk_i,              // system clock, 10 MHz
    input  wire logic                   reset_i,            // power-on reset, sync, high
    input  wire logic                   rst_n_i,            // reset pin, active low
    input  wire logic                   sclk_i,             // link clock
    input  wire logic                   cs_n_i,             // link select, active low
    input  wire logic                   din_i,              // link data in
    output logic                        dout_o,             // link data out
    input  wire logic                   sample_strobe_i,    // one pulse per finished sample
    input  wire incl_pkg::incl_sample_s sample_i,           // converted readings
    input  wire incl_pkg::incl_word_t   diag_flags_i,       // diagnostic cause flags
    input  wire logic                   general_line_one_i, // line one pin level
    output logic                        general_line_one_o, // line one drive value
    output logic                        general_line_one_oe_o, // line one drive enable
    input  wire logic                   general_line_two_i, // line two pin level
    output logic                        general_line_two_o, // line two drive value
    output logic                        general_line_two_oe_o, // line two drive enable
    output logic                        flash_update_o,     // pulse: mirror written
    output var incl_pkg::incl_cfg_s     cfg_o               // settings to the sensing path
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] ix(input logic [5:0] ofs);
        ix = ofs[5:1];
    endfunction : ix

    function automatic logic in_rng(input logic [5:0] ofs, input logic [5:0] lo, input logic [5:0] hi);
        in_rng = (ofs >= lo) && (ofs <= hi);
    endfunction : in_rng

    // reserved holes fall outside every range, so writes there are dropped
    function automatic logic is_rw(input logic [4:0] i);
        logic [5:0] ofs;
        ofs = {i, 1'b0};
        is_rw = in_rng(ofs, `INCL_OFS_XACC_OFF, `INCL_OFS_ANGLE_OFF)
             || in_rng(ofs, `INCL_OFS_ALM1_THR, `INCL_OFS_ALARM_SOURCE_CONTROL)
             || in_rng(ofs, `INCL_OFS_DAC, `INCL_OFS_SLP);
    endfunction : is_rw

    function automatic logic is_flash(input logic [4:0] i);
        logic [5:0] ofs;
        ofs = {i, 1'b0};
        is_flash = in_rng(ofs, `INCL_OFS_XACC_OFF, `INCL_OFS_ANGLE_OFF)
                || in_rng(ofs, `INCL_OFS_ALM1_THR, `INCL_OFS_ALARM_SOURCE_CONTROL)
                || in_rng(ofs, `INCL_OFS_SMPL, `INCL_OFS_SLP);
    endfunction : is_flash

    function automatic incl_pkg::incl_word_t rst_val(input logic [4:0] i);
        logic [5:0] ofs;
        ofs = {i, 1'b0};
        if (ofs == `INCL_OFS_SMPL) begin
            rst_val = `INCL_RST_SMPL;
        end else if (ofs == `INCL_OFS_AVG) begin
            rst_val = `INCL_RST_AVG;
        end else begin
            rst_val = `INCL_RST_ZERO;
        end
    endfunction : rst_val

    localparam logic [4:0] IX_XOFF = ix(`INCL_OFS_XACC_OFF);
    localparam logic [4:0] IX_YOFF = ix(`INCL_OFS_YACC_OFF);
    localparam logic [4:0] IX_SMPL = ix(`INCL_OFS_SMPL);
    localparam logic [4:0] IX_GPIO = ix(`INCL_OFS_GPIO);

    ////////////////////////////////////////////////////////////////////////
    incl_pkg::incl_cmd_s    link_cmd;
    logic                   link_tgl;
    incl_pkg::incl_word_t   resp_q;
    logic                   tgl_s1_q;
    logic                   tgl_s2_q;
    logic                   tgl_s3_q;
    logic                   rpin_s1_q;
    logic                   rpin_s2_q;
    logic [1:0]             gline_s1_q;
    logic [1:0]             gline_s2_q;
    logic                   cmd_take;
    logic                   pin_rst;
    logic                   wr_go;
    logic                   flash_go;
    logic [4:0]             cmd_ix;
    logic [5:0]             rd_ofs;
    incl_pkg::incl_word_t   cfg_q [0:31];
    incl_pkg::incl_word_t   mirror_q [0:31];
    incl_pkg::incl_word_t   endur_q;
    incl_pkg::incl_sample_s samp_q;
    logic                   nd_q;
    logic                   ea;
    logic [1:0]             flags;
    incl_pkg::incl_word_t   rd_word;

    incl_spi_link u_link (
        .reset_i (reset_i),
        .sclk_i  (sclk_i),
        .cs_n_i  (cs_n_i),
        .din_i   (din_i),
        .resp_i  (resp_q),
        .dout_o  (dout_o),
        .cmd_o   (link_cmd),
        .tgl_o   (link_tgl)
    );

    ////////////////////////////////////////////////////////////////////////
    // crossings: frame toggle, reset pin, line levels
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end else begin
            tgl_s1_q <= link_tgl;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rpin_s1_q <= 1'b1;
            rpin_s2_q <= 1'b1;
        end else begin
            rpin_s1_q <= rst_n_i;
            rpin_s2_q <= rpin_s1_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            gline_s1_q <= 2'h0;
            gline_s2_q <= 2'h0;
        end else begin
            gline_s1_q <= {general_line_two_i, general_line_one_i};
            gline_s2_q <= gline_s1_q;
        end
    end

    // the command word is static for a whole frame spacing, far longer
    // than the three-cycle toggle path, so it is read without its own sync
    assign cmd_take = tgl_s2_q ^ tgl_s3_q;
    assign pin_rst  = ~rpin_s2_q;
    assign cmd_ix   = ix(link_cmd.addr);
    assign rd_ofs   = {cmd_ix, 1'b0};
    assign wr_go    = cmd_take && link_cmd.wr && !pin_rst;
    assign flash_go = wr_go && link_cmd.addr == `INCL_OFS_TRIG
                      && link_cmd.data[`INCL_TRIG_FLASH];

    ////////////////////////////////////////////////////////////////////////
    // working copies of the settings
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < 32; i++) begin
                cfg_q[i] <= rst_val(5'(i));
            end
        end else if (pin_rst) begin
            for (int i = 0; i < 32; i++) begin
                cfg_q[i] <= is_flash(5'(i)) ? mirror_q[i] : rst_val(5'(i));
            end
        end else if (wr_go && is_rw(cmd_ix)) begin
            if (link_cmd.addr[0]) begin
                cfg_q[cmd_ix][15:8] <= link_cmd.data;
            end else begin
                cfg_q[cmd_ix][7:0] <= link_cmd.data;
            end
        end
    end

    // nonvolatile copies: touched only by the update command
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < 32; i++) begin
                mirror_q[i] <= rst_val(5'(i));
            end
        end else if (flash_go) begin
            for (int i = 0; i < 32; i++) begin
                if (is_flash(5'(i))) begin
                    mirror_q[i] <= cfg_q[i];
                end
            end
        end
    end

    // counter survives the reset pin, as it lives in the flash
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            endur_q <= 16'h0000;
        end else if (flash_go) begin
            endur_q <= endur_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flash_update_o <= 1'b0;
        end else begin
            flash_update_o <= flash_go;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readings and flags
    always_ff @(posedge clk_i) begin
        if (reset_i || pin_rst) begin
            samp_q <= '0;
        end else if (sample_strobe_i) begin
            samp_q <= sample_i;
        end
    end

    // a sample landing on the reading cycle keeps the flag set
    always_ff @(posedge clk_i) begin
        if (reset_i || pin_rst) begin
            nd_q <= 1'b0;
        end else if (sample_strobe_i) begin
            nd_q <= 1'b1;
        end else if (cmd_take && !link_cmd.wr && in_rng(rd_ofs, `INCL_OFS_SUPPLY, `INCL_OFS_ANGLE)) begin
            nd_q <= 1'b0;
        end
    end

    assign ea    = |diag_flags_i;
    assign flags = {nd_q, ea};

    ////////////////////////////////////////////////////////////////////////
    // read decode; write-only and reserved words read zero
    always_comb begin
        rd_word = 16'h0000;
        case (rd_ofs)
            `INCL_OFS_ENDUR:  rd_word = endur_q;
            `INCL_OFS_SUPPLY: rd_word = {flags, samp_q.supply};
            `INCL_OFS_XACC:   rd_word = {flags, samp_q.x_accel};
            `INCL_OFS_YACC:   rd_word = {flags, samp_q.y_accel};
            `INCL_OFS_AUX:    rd_word = {flags, 2'h0, samp_q.aux};
            `INCL_OFS_TEMP:   rd_word = {flags, 2'h0, samp_q.temp};
            `INCL_OFS_XTILT:  rd_word = {flags, samp_q.x_tilt};
            `INCL_OFS_YTILT:  rd_word = {flags, samp_q.y_tilt};
            `INCL_OFS_ANGLE:  rd_word = {flags, samp_q.angle};
            `INCL_OFS_GPIO:   rd_word = {6'h00, gline_s2_q, 6'h00, cfg_q[IX_GPIO][1:0]};
            `INCL_OFS_DIAG:   rd_word = diag_flags_i;
            `INCL_OFS_SLP:    rd_word = 16'h0000;
            `INCL_OFS_TRIG:   rd_word = 16'h0000;
            default:          rd_word = is_rw(cmd_ix) ? cfg_q[cmd_ix] : 16'h0000;
        endcase
    end

    // answer shifts out in the frame after the one that asked
    always_ff @(posedge clk_i) begin
        if (reset_i || pin_rst) begin
            resp_q <= 16'h0000;
        end else if (cmd_take) begin
            resp_q <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outward settings and general lines
    always_comb begin
        cfg_o.x_accel_offset             = cfg_q[ix(`INCL_OFS_XACC_OFF)];
        cfg_o.y_accel_offset             = cfg_q[ix(`INCL_OFS_YACC_OFF)];
        cfg_o.x_tilt_offset              = cfg_q[ix(`INCL_OFS_XTILT_OFF)];
        cfg_o.y_tilt_offset              = cfg_q[ix(`INCL_OFS_YTILT_OFF)];
        cfg_o.vertical_angle_offset      = cfg_q[ix(`INCL_OFS_ANGLE_OFF)];
        cfg_o.alarm1_threshold           = cfg_q[ix(`INCL_OFS_ALM1_THR)];
        cfg_o.alarm2_threshold           = cfg_q[ix(`INCL_OFS_ALM2_THR)];
        cfg_o.alarm1_period              = cfg_q[ix(`INCL_OFS_ALM1_PER)];
        cfg_o.alarm2_period              = cfg_q[ix(`INCL_OFS_ALM2_PER)];
        cfg_o.alarm_source_control       = cfg_q[ix(`INCL_OFS_ALARM_SOURCE_CONTROL)];
        cfg_o.analog_output_code         = cfg_q[ix(`INCL_OFS_DAC)];
        cfg_o.dataready_selftest_control = cfg_q[ix(`INCL_OFS_MISC)];
        cfg_o.sample_period_config       = cfg_q[IX_SMPL];
        cfg_o.filter_length_config       = cfg_q[ix(`INCL_OFS_AVG)];
        cfg_o.sleep_duration             = cfg_q[ix(`INCL_OFS_SLP)];
    end

    assign general_line_one_o    = cfg_q[IX_GPIO][`INCL_GPIO_DAT_LSB];
    assign general_line_two_o    = cfg_q[IX_GPIO][`INCL_GPIO_DAT_LSB + 1];
    assign general_line_one_oe_o = cfg_q[IX_GPIO][`INCL_GPIO_DIR_LSB];
    assign general_line_two_oe_o = cfg_q[IX_GPIO][`INCL_GPIO_DIR_LSB + 1];

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_nd_on_sample: assert property (
        sample_strobe_i && !pin_rst |=> nd_q ##1 (nd_q || $past(cmd_take)))
        else $error("new data flag not set by sample");

    a_nd_read_clear: assert property (
        cmd_take && !link_cmd.wr && in_rng(rd_ofs, `INCL_OFS_SUPPLY, `INCL_OFS_ANGLE)
        && !sample_strobe_i |=> !nd_q)
        else $error("new data flag kept after output read");

    a_word_flags: assert property (
        cmd_take && !pin_rst && !link_cmd.wr && in_rng(rd_ofs, `INCL_OFS_SUPPLY, `INCL_OFS_ANGLE)
        |=> resp_q[15] == $past(nd_q) && resp_q[14] == $past(|diag_flags_i))
        else $error("flag bits wrong in output word");

    a_short_pad: assert property (
        cmd_take && !pin_rst && (rd_ofs == `INCL_OFS_AUX || rd_ofs == `INCL_OFS_TEMP)
        |=> resp_q[13:12] == 2'h0
            && resp_q[11:0] == ($past(rd_ofs) == `INCL_OFS_AUX ? $past(samp_q.aux) : $past(samp_q.temp)))
        else $error("short reading not zero padded");

    a_flash_count: assert property (
        flash_go |=> endur_q == $past(endur_q) + 16'h0001 ##1 endur_q == $past(endur_q, 2) + 16'h0001
                     || $past(flash_go))
        else $error("flash counter did not step by one");

    a_mirror_copy: assert property (
        flash_go |=> mirror_q[IX_YOFF] == $past(cfg_q[IX_YOFF]))
        else $error("mirror not updated by trigger");

    a_mirror_hold: assert property (
        !flash_go |=> mirror_q[IX_XOFF] == $past(mirror_q[IX_XOFF]))
        else $error("mirror changed without trigger");

    a_upper_byte: assert property (
        wr_go && link_cmd.addr == (`INCL_OFS_XACC_OFF + 6'h01)
        |=> cfg_q[IX_XOFF] == {$past(link_cmd.data), $past(cfg_q[IX_XOFF][7:0])})
        else $error("upper byte write misplaced");

    a_wo_reads_zero: assert property (
        cmd_take && !pin_rst && (rd_ofs == `INCL_OFS_SLP || rd_ofs == `INCL_OFS_TRIG) |=> resp_q == 16'h0000)
        else $error("write-only register read back nonzero");

    a_pin_reload: assert property (
        pin_rst |=> cfg_q[IX_YOFF] == $past(mirror_q[IX_YOFF]) && resp_q == 16'h0000)
        else $error("reset pin did not reload settings");

    a_lower_byte: assert property (
        wr_go && link_cmd.addr == `INCL_OFS_XACC_OFF
        |=> cfg_q[IX_XOFF] == {$past(cfg_q[IX_XOFF][15:8]), $past(link_cmd.data)})
        else $error("lower byte write misplaced");

    a_resp_hold: assert property (
        !cmd_take && !pin_rst |=> $stable(resp_q))
        else $error("response word changed without a command");

    a_cfg_write_only: assert property (
        !wr_go && !pin_rst |=> cfg_q[IX_XOFF] == $past(cfg_q[IX_XOFF]))
        else $error("setting changed without a write");

    c_flash_update: cover property (flash_go);
    c_output_read:  cover property (cmd_take && !link_cmd.wr && rd_ofs == `INCL_OFS_XTILT ##1 !nd_q);
    c_pin_reset:    cover property (pin_rst ##1 !pin_rst);
    c_set_on_clear: cover property (sample_strobe_i && cmd_take && !link_cmd.wr);
endmodule : incl_regs
`default_nettype wire

//--- logic/incl_spi_link.sv
`timescale 1ns/10ps
`default_nettype none
module incl_spi_link (
    input  wire logic                reset_i, // chip reset, clears the held command and frame toggle
    input  wire logic                sclk_i,  // link clock, idles high
    input  wire logic                cs_n_i,  // frame select, active low
    input  wire logic                din_i,   // command bit in
    input  wire incl_pkg::incl_word_t resp_i, // response word, held stable
    output logic                     dout_o,  // response bit out
    output var incl_pkg::incl_cmd_s  cmd_o,   // last complete command
    output logic                     tgl_o    // toggles per complete frame
);
    logic [3:0]           bit_cnt_q;
    logic [14:0]          shift_q;
    logic                 launched_q;
    incl_pkg::incl_word_t tx_q;

    // counter ends with the frame's own select, so no edge is needed after it
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt_q <= 4'h0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge sclk_i) begin
        shift_q <= {shift_q[13:0], din_i};
    end

    // short frames never reach the last count and leave no trace
    always_ff @(posedge sclk_i or posedge reset_i) begin
        if (reset_i) begin
            cmd_o <= '0;
            tgl_o <= 1'b0;
        end else if (!cs_n_i && bit_cnt_q == 4'hf) begin
            cmd_o <= {shift_q, din_i};
            tgl_o <= ~tgl_o;
        end
    end

    // first falling edge loads, later ones shift, while commands shift in
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            tx_q       <= 16'h0000;
            launched_q <= 1'b0;
        end else begin
            launched_q <= 1'b1;
            tx_q       <= launched_q ? {tx_q[14:0], 1'b0} : resp_i;
        end
    end

    assign dout_o = tx_q[15];
endmodule : incl_spi_link
`default_nettype wire

//--- testbench/incl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module incl_host (
    output logic      sclk_o, // link clock, idles high
    output logic      cs_n_o, // frame select, active low
    output logic      din_o,  // command bit to device
    input  wire logic dout_i  // response bit from device
);
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end
    // n below 16 gives a torn frame on purpose
    task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] rsp);
        cs_n_o = 1'b0;
        #60;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b0; // launch on fall, sample on rise
            din_o  = cmd[15-i]; // write bit, spare, address, data
            #7.5;
            sclk_o = 1'b1;
            rsp    = {rsp[14:0], dout_i}; // full duplex
            #7.5;
        end
        #60;
        cs_n_o = 1'b1; // clock stays high between frames
        din_o  = ~din_o;
        #40000; // frame spacing
    endtask : xfer
endmodule : incl_host
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                   clk_i, reset_i, rst_n, stb, sclk, cs_n, din, dout;
    logic                   g1_o, g1_oe, g2_o, g2_oe, fl;
    incl_pkg::incl_sample_s smp;
    incl_pkg::incl_word_t   diag;
    incl_pkg::incl_cfg_s    cfg;
    int                     err_total, checks, fl_cnt;
    wire logic              g1_pin = g1_oe ? g1_o : 1'b0;
    wire logic              g2_pin = g2_oe ? g2_o : 1'b1;

    incl_regs DUT (.clk_i(clk_i), .reset_i(reset_i), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n),
        .din_i(din), .dout_o(dout), .sample_strobe_i(stb), .sample_i(smp), .diag_flags_i(diag),
        .general_line_one_i(g1_pin), .general_line_one_o(g1_o), .general_line_one_oe_o(g1_oe),
        .general_line_two_i(g2_pin), .general_line_two_o(g2_o), .general_line_two_oe_o(g2_oe),
        .flash_update_o(fl), .cfg_o(cfg));
    incl_host host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (fl === 1'b1) fl_cnt++;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] r;
        host.xfer({2'b10, a, d}, 16, r); // no write scenario aims at 0x1c-0x1f
    endtask : wr
    // answer comes back one frame later
    task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] r;
        host.xfer({2'b00, a, 8'h00}, 16, r);
        host.xfer({2'b00, a, 8'h00}, 16, r);
        chk($sformatf("reg %h", a), r, exp);
    endtask : rdc
    task automatic sample(input incl_pkg::incl_sample_s s);
        @(posedge clk_i);
        smp <= s;
        stb <= 1'b1;
        @(posedge clk_i);
        stb <= 1'b0;
    endtask : sample
    ////////////////////////////////////////////////////////////////////////
    task automatic t_bytes;
        rdc(6'h36, 16'h0014);
        rdc(6'h38, 16'h0008);
        rdc(6'h3e, 16'h0000);
        rdc(6'h1c, 16'h0000);
        wr(6'h12, 8'h34);
        wr(6'h13, 8'h12);
        rdc(6'h13, 16'h1234);
        chk("x offset", cfg.x_accel_offset, 16'h1234);
        wr(6'h29, 8'h5a);
        rdc(6'h28, 16'h5a00);
    endtask : t_bytes
    task automatic t_outputs;
        sample('{14'h2a3d, 14'h3fff, 14'h0001, 12'hccc, 12'h4fe, 14'h0123, 14'h3ffe, 14'h2000});
        rdc(6'h02, 16'haa3d);
        rdc(6'h08, 16'h0ccc);
        rdc(6'h06, 16'h0001);
        rdc(6'h0c, 16'h0123);
        rdc(6'h0f, 16'h3ffe);
        @(posedge clk_i);
        diag <= 16'h0010;
        wr(6'h04, 8'h00);
        rdc(6'h04, 16'h7fff);
        rdc(6'h0a, 16'h44fe);
        rdc(6'h3c, 16'h0010);
        sample('{14'h0, 14'h0, 14'h0, 12'h0, 12'h0, 14'h0, 14'h0, 14'h2000});
        rdc(6'h10, 16'he000);
    endtask : t_outputs
    task automatic t_flash;
        logic [15:0] r;
        host.xfer({2'b10, 6'h30, 8'h77}, 8, r);
        rdc(6'h30, 16'h0000);
        wr(6'h3a, 8'h08);
        rdc(6'h3a, 16'h0000);
        chk("sleep", cfg.sleep_duration, 16'h0008);
        wr(6'h14, 8'h55);
        wr(6'h3e, 8'h08);
        chk("pulses", 16'(fl_cnt), 16'h0001);
        rdc(6'h00, 16'h0001);
        wr(6'h14, 8'haa);
        wr(6'h34, 8'h05);
        @(posedge clk_i);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        rdc(6'h14, 16'h0055);
        rdc(6'h34, 16'h0000);
        rdc(6'h00, 16'h0001);
    endtask : t_flash
    task automatic t_gpio;
        wr(6'h32, 8'h03);
        wr(6'h33, 8'h01);
        chk("lines", {12'h0, g2_oe, g1_oe, g2_o, g1_o}, 16'h000d);
        repeat (4) @(posedge clk_i);
        rdc(6'h32, 16'h0103);
    endtask : t_gpio
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        {reset_i, rst_n, stb, smp, diag} = {1'b1, 1'b1, 1'b0, 108'h0, 16'h0};
        {err_total, checks, fl_cnt} = '0;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        t_bytes();
        t_outputs();
        t_flash();
        t_gpio();
        tally_and_finish();
    end
    initial begin
        #6000000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
